// >>> core/can_csr_pkg.sv
// Constants for the CAN control and status register block.
// Assumes APB word access; register index times four is the byte address.
package can_csr_pkg;
   // Register indices (byte address is index * 4)
   localparam logic [7:0] IDX_CONTROL = 8'h00;
   localparam logic [7:0] IDX_STATUS = 8'h01;
   localparam logic [7:0] IDX_CPU_IF = 8'h02;
   localparam logic [7:0] IDX_INTREG = 8'h5F;
   localparam int N_CFG = 6;
   localparam logic [7:0] CFG_IDX [0:N_CFG-1] = '{8'h1F, 8'h2F, 8'h3F, 8'h4F, 8'h9F, 8'hAF};
   localparam int ADDR_W = 10;
   // Control field positions
   localparam int CTL_INIT = 0;
   localparam int CTL_IE = 1;
   localparam int CTL_SIE = 2;
   localparam int CTL_EIE = 3;
   localparam int CTL_CCE = 6;
   // Status field positions
   localparam int ST_LEC_LO = 0;
   localparam int ST_TX_SUCCESS_FLAG = 3;
   localparam int ST_RX_SUCCESS_FLAG = 4;
   localparam int ST_WAKE = 5;
   localparam int ST_WARN = 6;
   localparam int ST_BUS_OFF_FLAG = 7;
   // Power control field positions
   localparam int CPU_SLEEP = 3;
   localparam int CPU_PD = 4;
   // Reset values and the status-change interrupt code
   localparam logic [7:0] CONTROL_RESET = 8'h01;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] INT_STATUS_CHANGE = 8'h01;
   // Counts
   localparam int IDLE_BITS = 11;
   localparam int RECOVERY_IDLES = 128;
   localparam int CNT_W = 9;
   localparam int BUS_OFF_LIMIT = 256;
   localparam int WARN_LIMIT = 96;
   // Last error codes
   typedef enum logic [2:0] {
      LEC_NONE = 3'h0, LEC_STUFF = 3'h1, LEC_FORM = 3'h2, LEC_ACK = 3'h3,
      LEC_BIT1 = 3'h4, LEC_BIT0 = 3'h5, LEC_CRC = 3'h6, LEC_UNUSED = 3'h7
   } lec_e;
   // Bus participation states, one-hot
   typedef enum logic [3:0] {
      S_INIT = 4'b0001, S_SYNC = 4'b0010, S_ACTIVE = 4'b0100, S_RECOVER = 4'b1000
   } bus_state_e;
endpackage

// >>> core/can_csr_if.sv
// Internal carriers between the register block and its helpers.
// Assumes one clock; all signals are on pclk.
`timescale 1ns/1ps
`default_nettype none
// Bus idle detection: bit strobe and sampled level in, idle pulse out
interface idle_if;
   logic bit_tick;
   logic rx_recessive;
   logic idle_pulse;
   modport owner (output bit_tick, output rx_recessive, input idle_pulse);
   modport detector (input bit_tick, input rx_recessive, output idle_pulse);
endinterface
// Error counter levels: counters in, threshold flags out
interface level_if;
   logic [8:0] tx_cnt;
   logic [8:0] rx_cnt;
   logic bus_off_hit;
   logic warn_level;
   modport owner (output tx_cnt, output rx_cnt, input bus_off_hit, input warn_level);
   modport judge (input tx_cnt, input rx_cnt, output bus_off_hit, output warn_level);
endinterface
`default_nettype wire

// >>> core/bus_idle_detect.sv
// Counts consecutive recessive bits and pulses once per eleven.
// Assumes bit_tick is a one-cycle sample-point strobe on pclk.
`timescale 1ns/1ps
`default_nettype none
module bus_idle_detect
   import can_csr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   idle_if.detector idl
);
   logic [3:0] run_ff; // Recessive bits seen in a row
   logic pulse_ff;
   wire last_bit = (run_ff == 4'(IDLE_BITS - 1));

   ////////////////////////////////////////////////////////////////////////
   // Dominant bit restarts the run; a full run pulses and starts over
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_ff <= 4'h0;
         pulse_ff <= 1'b0;
      end else begin
         pulse_ff <= idl.bit_tick & idl.rx_recessive & last_bit;
         if (idl.bit_tick) begin
            run_ff <= (!idl.rx_recessive || last_bit) ? 4'h0 : run_ff + 4'h1;
         end
      end
   end
   assign idl.idle_pulse = pulse_ff;
endmodule
`default_nettype wire

// >>> core/err_level_judge.sv
// Compares the two error counters against the warning and bus-off limits.
// Assumes the counters are kept by the protocol engine on pclk.
`timescale 1ns/1ps
`default_nettype none
module err_level_judge
   import can_csr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   level_if.judge lvl
);
   localparam logic [CNT_W-1:0] OFF_LIM = CNT_W'(BUS_OFF_LIMIT);
   localparam logic [CNT_W-1:0] WARN_LIM = CNT_W'(WARN_LIMIT);
   logic off_ff;
   logic warn_ff;

   ////////////////////////////////////////////////////////////////////////
   // Registered so the flags move one cycle after the counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_ff <= 1'b0;
         warn_ff <= 1'b0;
      end else begin
         off_ff <= (lvl.tx_cnt >= OFF_LIM) | (lvl.rx_cnt >= OFF_LIM);
         warn_ff <= (lvl.tx_cnt >= WARN_LIM) | (lvl.rx_cnt >= WARN_LIM);
      end
   end
   assign lvl.bus_off_hit = off_ff;
   assign lvl.warn_level = warn_ff;
endmodule
`default_nettype wire

// >>> core/can_control_status_regs.sv
// Control, status and interrupt register logic of a CAN controller.
// Assumes an APB master on pclk and a protocol engine that obeys
// frame_enable and reports events as one-cycle pulses on pclk.
// Functional notes
// [R1] Control reads 01H after hardware reset
// [R2] Config writes only while unlock bit set
// [R3] Software relocks config after initialization
// [R4] Bus-off or warning change raises error interrupt
// [R5] Status-change interrupt on wake, ok, error code
// [R6] Status and object interrupts both raised
// [R7] Output quiet without global enable; register updates
// [R8] Enabling with pending value asserts output at once
// [R9] Reset or bus-off sets initialization hold
// [R10] Initialization hold stops frames, outputs recessive
// [R11] Frame in progress completes despite hold
// [R12] Reserved control bits read zero, written zero
// [R13] Bus-off at 256 errors; no traffic
// [R14] Recovery clears counters, waits 128 idles
// [R15] Warning at 96 errors, may interrupt
// [R16] Wake zero in sleep, set on exit
// [R17] Status read clears wake flag
// [R18] Receive success set per clean frame
// [R19] Transmit success set when sent and acknowledged
// [R20] Error code first per frame, cleared after clean
// [R21] Error codes one through six by type
// [R22] No bit errors in arbitration; recovery writes five
// [R23] Wait one bus idle before bus activity
// [R24] Status read removes pending status-change value
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module can_control_status_regs
   import can_csr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [can_csr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic can_rx,
   input wire logic bit_tick,
   input wire logic core_tx_bit,
   input wire logic frame_active,
   input wire logic frame_sof,
   input wire logic rx_frame_ok,
   input wire logic tx_frame_ok,
   input wire logic err_valid,
   input wire logic [2:0] err_code,
   input wire logic err_in_arb,
   input wire logic [8:0] tx_err_cnt,
   input wire logic [8:0] rx_err_cnt,
   input wire logic [7:0] msg_irq_code,
   output logic tx_out_a,
   output logic tx_out_b,
   output logic frame_enable,
   output logic err_cnt_clear,
   output logic irq_out,
   output logic sleep_mode,
   output logic power_down_request,
   output logic [8*can_csr_pkg::N_CFG-1:0] cfg_out
);
   import can_csr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic rx_meta_ff, rx_sync_ff; // Pin synchroniser
   logic [7:0] ctl_ff; // Control bits as stored
   logic [7:0] cfg_ff [0:N_CFG-1]; // Configuration words
   logic sleep_ff, pd_ff; // Low power requests
   logic wake_ff, rx_success_flag_ff, tx_success_flag_ff;
   logic [2:0] lec_ff;
   logic err_seen_ff; // First error of this frame already logged
   logic bus_off_ff, warn_prev_ff, bus_off_flag_prev_ff;
   logic status_pend_ff; // Status-change interrupt source pending
   logic [7:0] rec_cnt_ff; // Idle periods seen during recovery
   bus_state_e state_ff, nxt_state;
   logic tx_a_ff, tx_b_ff, fen_ff, clr_ff, irq_ff;
   logic [31:0] rdata_ff;
   logic ready_ff, slverr_ff;
   idle_if idl ();
   level_if lvl ();

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   bus_idle_detect u_idle (
      .pclk(pclk),
      .presetn(presetn),
      .idl(idl)
   );
   err_level_judge u_level (
      .pclk(pclk),
      .presetn(presetn),
      .lvl(lvl)
   );
   assign idl.bit_tick = bit_tick;
   assign idl.rx_recessive = rx_sync_ff;
   assign lvl.tx_cnt = tx_err_cnt;
   assign lvl.rx_cnt = rx_err_cnt;

   ////////////////////////////////////////////////////////////////////////
   // APB decode
   wire aligned = (paddr[1:0] == 2'b00);
   wire [7:0] idx = paddr[9:2];
   wire setup = psel & ~penable;
   wire done = psel & penable & ready_ff; // Completing edge
   wire wr = done & pwrite;
   wire rd = done & ~pwrite;
   wire hit_ctl = aligned & (idx == IDX_CONTROL);
   wire hit_st = aligned & (idx == IDX_STATUS);
   wire hit_cpu = aligned & (idx == IDX_CPU_IF);
   wire hit_int = aligned & (idx == IDX_INTREG);
   logic [N_CFG-1:0] hit_cfg;
   wire cce = ctl_ff[CTL_CCE];
   wire init_bit = ctl_ff[CTL_INIT];
   wire [7:0] wbyte = pwdata[7:0];
   wire st_rd = rd & hit_st;
   wire wr_ctl = wr & hit_ctl;
   wire wr_st = wr & hit_st;
   wire wr_cpu = wr & hit_cpu;

   // Per-register decode and storage for the locked configuration words
   genvar gi;
   generate
      for (gi = 0; gi < N_CFG; gi = gi + 1) begin : g_cfg
         assign hit_cfg[gi] = aligned & (idx == CFG_IDX[gi]);
         assign cfg_out[8*gi +: 8] = cfg_ff[gi];
         // [R2] Unlock gates writes
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cfg_ff[gi] <= CFG_RESET;
            end else if (wr & hit_cfg[gi] & cce) begin
               cfg_ff[gi] <= wbyte;
            end
         end
      end
   endgenerate

   wire hit_any = hit_ctl | hit_st | hit_cpu | hit_int | (|hit_cfg);

   ////////////////////////////////////////////////////////////////////////
   // Event decode from the protocol engine and helpers
   wire idle = idl.idle_pulse;
   wire st_init = (state_ff == S_INIT);
   wire st_act = (state_ff == S_ACTIVE);
   wire st_rec = (state_ff == S_RECOVER);
   // [R13] Bus-off entry at counter limit
   wire bus_off_flag_enter = lvl.bus_off_hit & ~bus_off_ff & ~st_rec;
   wire rec_done = st_rec & idle & (rec_cnt_ff == 8'(RECOVERY_IDLES - 1));
   // [R22] Bit errors ignored in arbitration
   wire bit_err = (err_code == LEC_BIT1) | (err_code == LEC_BIT0);
   wire err_take = err_valid & ~err_seen_ff & ~(err_in_arb & bit_err);
   wire lec_rec = st_rec & idle;
   wire lec_load = err_take | lec_rec;
   // [R16] Wake sources
   wire bus_act = sleep_ff & ~rx_sync_ff;
   wire sleep_off = wr_cpu & sleep_ff & ~wbyte[CPU_SLEEP];
   wire pd_off = wr_cpu & pd_ff & ~wbyte[CPU_PD];
   wire wake_set = bus_act | sleep_off | pd_off;
   // [R4] [R15] Error flag changes
   wire err_chg = (bus_off_ff != bus_off_flag_prev_ff) | (lvl.warn_level != warn_prev_ff);
   // [R5] Status-change sources
   wire sc_evt = wake_set | rx_frame_ok | tx_frame_ok | lec_load;
   wire pend_set = (ctl_ff[CTL_SIE] & sc_evt) | (ctl_ff[CTL_EIE] & err_chg);
   // [R7] Interrupt register value independent of global enable
   wire [7:0] int_val = status_pend_ff ? INT_STATUS_CHANGE : msg_irq_code;
   wire drive = ~bus_off_ff & (st_act | frame_active);

   ////////////////////////////////////////////////////////////////////////
   // Read data multiplexer
   wire [7:0] st_val = {bus_off_ff, lvl.warn_level, wake_ff, rx_success_flag_ff, tx_success_flag_ff, lec_ff};
   wire [7:0] cpu_val = {3'b000, pd_ff, sleep_ff, 3'b000};
   logic [7:0] cfg_rd;
   always_comb begin
      cfg_rd = 8'h00;
      for (int i = 0; i < N_CFG; i++) begin
         if (hit_cfg[i]) begin
            cfg_rd = cfg_ff[i];
         end
      end
   end
   // [R12] Reserved control bits stored as zero
   wire [7:0] rd_byte = hit_ctl ? ctl_ff :
                        hit_st ? st_val :
                        hit_cpu ? cpu_val :
                        hit_int ? int_val : cfg_rd;

   ////////////////////////////////////////////////////////////////////////
   // Bus participation state machine
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         S_INIT: begin
            // Recovery only after bus-off; otherwise plain resync
            if (!init_bit) begin
               nxt_state = bus_off_ff ? S_RECOVER : S_SYNC;
            end
         end
         S_SYNC: begin
            // [R23] One bus idle before joining
            if (init_bit) begin
               nxt_state = S_INIT;
            end else if (idle) begin
               nxt_state = S_ACTIVE;
            end
         end
         S_ACTIVE: begin
            if (init_bit) begin
               nxt_state = S_INIT;
            end
         end
         S_RECOVER: begin
            // Setting hold again cannot hasten recovery
            if (init_bit) begin
               nxt_state = S_INIT;
            end else if (rec_done) begin
               nxt_state = S_ACTIVE;
            end
         end
         default: nxt_state = S_INIT;
      endcase
      if (bus_off_flag_enter) begin
         nxt_state = S_INIT;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser; only the second stage is read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_meta_ff <= 1'b1;
         rx_sync_ff <= 1'b1;
      end else begin
         rx_meta_ff <= can_rx;
         rx_sync_ff <= rx_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register and state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // [R1] Hold set, enables clear
         ctl_ff <= CONTROL_RESET;
         state_ff <= S_INIT;
      end else begin
         state_ff <= nxt_state;
         if (wr_ctl) begin
            // [R12] Reserved bits forced to zero
            ctl_ff <= wbyte & 8'h4F;
         end
         if (bus_off_flag_enter) begin
            // [R9] Bus-off sets hold
            ctl_ff[CTL_INIT] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus-off flag and recovery counting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_off_ff <= 1'b0;
         rec_cnt_ff <= 8'h00;
         clr_ff <= 1'b0;
      end else begin
         // [R14] Counters cleared on entering recovery
         clr_ff <= st_init & ~init_bit & bus_off_ff;
         if (bus_off_flag_enter) begin
            bus_off_ff <= 1'b1;
         end else if (rec_done) begin
            bus_off_ff <= 1'b0;
         end
         // [R14] Count idle periods
         if (!st_rec) begin
            rec_cnt_ff <= 8'h00;
         end else if (idle) begin
            rec_cnt_ff <= rec_cnt_ff + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Low power requests and wake flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_ff <= 1'b0;
         pd_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         if (wr_cpu) begin
            sleep_ff <= wbyte[CPU_SLEEP];
            pd_ff <= wbyte[CPU_PD];
         end else if (bus_act) begin
            // Bus activity ends sleep
            sleep_ff <= 1'b0;
         end
         // [R16] Cleared in sleep, set on exit; [R17] read clears, set wins
         if (wake_set) begin
            wake_ff <= 1'b1;
         end else if (st_rd | sleep_ff) begin
            wake_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Success flags and last error code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_success_flag_ff <= 1'b0;
         tx_success_flag_ff <= 1'b0;
         lec_ff <= LEC_NONE;
         err_seen_ff <= 1'b0;
      end else begin
         // [R18] [R19] Host write loads the written bit, hardware set wins
         rx_success_flag_ff <= rx_frame_ok | (wr_st ? wbyte[ST_RX_SUCCESS_FLAG] : rx_success_flag_ff);
         tx_success_flag_ff <= tx_frame_ok | (wr_st ? wbyte[ST_TX_SUCCESS_FLAG] : tx_success_flag_ff);
         // [R20] First error per frame, cleared by a clean frame
         if (frame_sof) begin
            err_seen_ff <= 1'b0;
         end else if (err_take) begin
            err_seen_ff <= 1'b1;
         end
         if (lec_rec) begin
            // [R22] Recessive run during recovery
            lec_ff <= LEC_BIT0;
         end else if (err_take) begin
            // [R21] Code passed through by type
            lec_ff <= err_code;
         end else if (rx_frame_ok | tx_frame_ok) begin
            lec_ff <= LEC_NONE;
         end else if (wr_st) begin
            lec_ff <= wbyte[ST_LEC_LO +: 3];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt pending and output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_pend_ff <= 1'b0;
         bus_off_flag_prev_ff <= 1'b0;
         warn_prev_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         bus_off_flag_prev_ff <= bus_off_ff;
         warn_prev_ff <= lvl.warn_level;
         // [R24] Status read removes pending value; new event wins
         if (pend_set) begin
            status_pend_ff <= 1'b1;
         end else if (st_rd) begin
            status_pend_ff <= 1'b0;
         end
         // [R6] [R7] [R8] Any nonzero source under global enable
         irq_ff <= ctl_ff[CTL_IE] & (int_val != 8'h00);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit outputs and frame start permission
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_a_ff <= 1'b1;
         tx_b_ff <= 1'b0;
         fen_ff <= 1'b0;
      end else begin
         // [R10] [R11] Recessive unless joined or finishing a frame
         tx_a_ff <= drive ? core_tx_bit : 1'b1;
         tx_b_ff <= drive ? ~core_tx_bit : 1'b0;
         // [R13] No new frame while bus-off or held
         fen_ff <= (nxt_state == S_ACTIVE) & ~bus_off_ff & ~bus_off_flag_enter;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB answer: no wait state, data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_ff <= 32'h0000_0000;
         ready_ff <= 1'b0;
         slverr_ff <= 1'b0;
      end else begin
         ready_ff <= setup;
         if (setup) begin
            rdata_ff <= hit_any ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            slverr_ff <= ~hit_any;
         end else if (done) begin
            slverr_ff <= 1'b0;
         end
      end
   end

   assign prdata = rdata_ff;
   assign pready = ready_ff;
   assign pslverr = slverr_ff;
   assign tx_out_a = tx_a_ff;
   assign tx_out_b = tx_b_ff;
   assign frame_enable = fen_ff;
   assign err_cnt_clear = clr_ff;
   assign irq_out = irq_ff;
   assign sleep_mode = sleep_ff;
   assign power_down_request = pd_ff;
endmodule
`default_nettype wire

// >>> tb/can_csr_props.sv
// Concurrent checks on the CAN register block, bound to its top module.
// Sees the top ports only; one clock domain, asynchronous low reset.
`timescale 1ns/1ps
`default_nettype none
module can_csr_props
   import can_csr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [can_csr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic can_rx,
   input wire logic frame_active,
   input wire logic [8:0] tx_err_cnt,
   input wire logic [7:0] msg_irq_code,
   input wire logic tx_out_a,
   input wire logic tx_out_b,
   input wire logic frame_enable,
   input wire logic err_cnt_clear,
   input wire logic irq_out
);
   logic ie_ff; // Global enable as last written by the host
   logic [5:0] rec_ff; // Recessive run length, saturating
   wire ctl_wr = psel && penable && pready && pwrite && paddr == 10'h000;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////
   // Shadow of the enable bit; the block never changes it on its own
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ie_ff <= 1'b0;
         rec_ff <= 6'h00;
      end else begin
         ie_ff <= ctl_wr ? pwdata[1] : ie_ff;
         rec_ff <= !can_rx ? 6'h00 : rec_ff + {5'h00, rec_ff != 6'h3F};
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   ack_once_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("access phase not exactly one cycle");
   rsv_zero_a: assert property (
      pready && !pwrite && paddr == 10'h000 |-> (prdata[7:0] & 8'hB0) == 8'h00)
      else $error("reserved control bits read nonzero");
   tx_pair_a: assert property (tx_out_b == !tx_out_a)
      else $error("transmit outputs not complementary");
   hold_quiet_a: assert property (
      (!frame_enable && !frame_active) [*2] |-> tx_out_a)
      else $error("dominant sent while frames are blocked");
   busoff_stop_a: assert property (tx_err_cnt[8] |-> ##[1:3] !frame_enable)
      else $error("frames still allowed at error limit");
   clr_pulse_a: assert property (err_cnt_clear |=> !err_cnt_clear)
      else $error("counter clear longer than one cycle");
   irq_quiet_a: assert property (!ie_ff && !$past(ie_ff) |-> !irq_out)
      else $error("interrupt output active while disabled");
   irq_pend_a: assert property (
      ie_ff && msg_irq_code != 8'h00 |-> ##[0:2] irq_out)
      else $error("pending interrupt not signalled");
   idle_wait_a: assert property ($rose(frame_enable) |-> rec_ff >= 6'h0B)
      else $error("frames enabled without bus idle");
endmodule
bind can_control_status_regs can_csr_props props (.*);
`default_nettype wire

// >>> tb/can_bus_model.sv
// Behavioural CAN bus seen through the transceiver, with bit timing.
// Assumes the block is the only node driving; the bus is wired-AND.
`timescale 1ns/1ps
`default_nettype none
module can_bus_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tx_out_a,
   output logic can_rx,
   output logic bit_tick
);
   logic [1:0] div_ff; // Bit time of four clocks keeps recovery short
   // Dominant zero from any node wins the wire
   assign can_rx = tx_out_a;
   // Sample-point strobe once per bit
   assign bit_tick = div_ff == 2'h3;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= 2'h0;
      end else begin
         div_ff <= div_ff + 2'h1;
      end
   end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench of the CAN register block, driven over APB.
// Assumes the bus model gives bit ticks; engine events come from here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, v) begin n_compared++; if ((v) !== (e)) begin error_cnt++; \
   $display("ERROR %s exp %0h got %0h", n, e, v); end end
module testbench;
   import can_csr_pkg::*;
   logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, err_in_arb = '0;
   logic core_tx_bit = '1, frame_active = '0, slv;
   logic [9:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pl = '0; // Engine pulses: error, tx ok, rx ok, start
   logic [2:0] err_code = '0;
   logic [8:0] tx_err_cnt = '0, rx_err_cnt = '0;
   logic [7:0] msg_irq_code = '0, q;
   wire logic [31:0] prdata;
   wire logic [47:0] cfg_out;
   wire logic pready, pslverr, can_rx, bit_tick, tx_out_a, tx_out_b, frame_enable;
   wire logic err_cnt_clear, irq_out, sleep_mode, power_down_request;
   wire logic frame_sof = pl[0], rx_frame_ok = pl[1], tx_frame_ok = pl[2], err_valid = pl[3];
   int error_cnt = 0, n_compared = 0, cyc = 0, t;
   can_control_status_regs dut (.*);
   can_bus_model bus (.*);
   initial forever #20 pclk = ~pclk;
   // Hang guard, well above the run length
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         end_of_test;
      end
   end
   task automatic end_of_test;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // One APB transfer; result taken at the edge that samples pready
   task automatic bus_op(input logic w, input logic [9:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata[7:0];
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] e, input string n);
      bus_op(1'b0, a, 8'h00);
      `CHK(n, e, q)
   endtask
   task automatic pulse(input logic [3:0] m);
      @(posedge pclk);
      pl <= m;
      @(posedge pclk);
      pl <= 4'h0;
      #1;
   endtask
   task automatic gap(input int k);
      repeat (k) @(posedge pclk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(10'h000, 8'h01, "control");
      rd(10'h004, 8'h00, "status");
      bus_op(1'b1, 10'h000, 8'h4E);
      for (int i = 0; i < N_CFG; i++) begin
         bus_op(1'b1, {CFG_IDX[i], 2'b00}, 8'hA0 + i[7:0]);
         `CHK("cfg_out", 8'hA0 + i[7:0], cfg_out[8*i+:8])
      end
      bus_op(1'b1, 10'h000, 8'h0E);
      for (int i = 0; i < N_CFG; i++) begin
         bus_op(1'b1, {CFG_IDX[i], 2'b00}, 8'h55);
         rd({CFG_IDX[i], 2'b00}, 8'hA0 + i[7:0], "cfg locked");
      end
      bus_op(1'b0, 10'h00C, 8'h00);
      `CHK("slverr", 1'b1, slv)
      pulse(4'b0110);
      gap(2);
      `CHK("irq ok", 1'b1, irq_out)
      rd(10'h17C, 8'h01, "int pend");
      rd(10'h004, 8'h18, "flags");
      rd(10'h17C, 8'h00, "int read");
      for (int c = 1; c < 7; c++) begin
         pulse(4'b0001);
         err_code <= c[2:0];
         pulse(4'b1000);
         err_code <= 3'(c % 6 + 1);
         pulse(4'b1000);
         rd(10'h004, {5'h00, c[2:0]} | 8'h18, "lec");
      end
      bus_op(1'b1, 10'h004, 8'h00);
      pulse(4'b0010);
      pulse(4'b0001);
      err_code <= 3'h4;
      err_in_arb <= 1'b1;
      pulse(4'b1000);
      rd(10'h004, 8'h10, "lec arb");
      err_in_arb <= 1'b0;
      bus_op(1'b1, 10'h004, 8'h07);
      rd(10'h004, 8'h07, "lec host");
      bus_op(1'b1, 10'h000, 8'h0C);
      rd(10'h004, 8'h07, "status");
      msg_irq_code <= 8'h03;
      gap(3);
      `CHK("irq off", 1'b0, irq_out)
      rd(10'h17C, 8'h03, "int kept");
      frame_active <= 1'b1;
      core_tx_bit <= 1'b0;
      bus_op(1'b1, 10'h000, 8'h0D);
      gap(2);
      `CHK("tx mid", 1'b0, tx_out_a)
      `CHK("fen mid", 1'b0, frame_enable)
      frame_active <= 1'b0;
      core_tx_bit <= 1'b1;
      bus_op(1'b1, 10'h000, 8'h0E);
      gap(2);
      `CHK("irq on", 1'b1, irq_out)
      msg_irq_code <= 8'h00;
      bus_op(1'b1, 10'h008, 8'h08);
      `CHK("sleep", 1'b1, sleep_mode)
      rd(10'h004, 8'h07, "wake sleep");
      bus_op(1'b1, 10'h008, 8'h00);
      rd(10'h004, 8'h27, "wake");
      rd(10'h004, 8'h07, "wake read");
      rx_err_cnt <= 9'h060;
      gap(3);
      rd(10'h004, 8'h47, "warn");
      `CHK("irq warn", 1'b1, irq_out)
      rx_err_cnt <= 9'h000;
      tx_err_cnt <= 9'h100;
      gap(3);
      `CHK("enable", 1'b0, frame_enable)
      `CHK("tx", 1'b1, tx_out_a)
      rd(10'h000, 8'h0F, "hold");
      rd(10'h004, 8'hC7, "busoff");
      bus_op(1'b1, 10'h000, 8'h0E);
      t = 0;
      while (err_cnt_clear !== 1'b1 && t < 10) begin gap(1); t++; end
      `CHK("clear", 1'b1, err_cnt_clear)
      tx_err_cnt <= 9'h000;
      t = 0;
      while (frame_enable !== 1'b1 && t < 8000) begin gap(1); t++; end
      // 128 idles of 11 four-clock bits; phase of the first idle unknown
      `CHK("recovery", 1'b1, t >= 5588 && t <= 5636)
      rd(10'h004, 8'h05, "recover");
      end_of_test;
   end
endmodule
`default_nettype wire
